// ==== tone_filter_pkg.sv ====
package tone_filter_pkg;

  localparam int PCM_BITS       = 8;
  localparam int PCM_CHANNELS   = 32;
  localparam int CHAN_BITS      = 5;
  localparam int LIN_BITS       = 16;
  localparam int TABLE_COUNT    = 4;
  localparam int TABLE_BITS     = 2;
  localparam int FILTER_COUNT   = 32;
  localparam int FILTER_BITS    = 5;
  localparam int ACTIVE_MAX     = 10;
  localparam int SLOT_BITS      = 4;
  localparam int GROUP_SAMPLES  = 64;
  localparam int GROUP_BITS     = 7;
  localparam int ACC_BITS       = 24;
  localparam int RESULT_BYTES   = 3;
  localparam int FIFO_DEPTH     = 4;
  localparam int COEF_BITS      = 16;
  // select ram: slots 0..9 filter numbers, slot 10 table, slot 11 active count
  localparam logic [3:0] SEL_TABLE_SLOT = 4'hA;
  localparam logic [3:0] SEL_COUNT_SLOT = 4'hB;
  localparam logic [7:0] SEL_RESET_VAL  = 8'h00;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] addr;
    logic       write;
  } cpu_req_type;

  typedef struct packed {
    logic [3:0] filter_slot;
    logic [1:0] byte_index;
    logic [7:0] data;
  } result_byte_type;

endpackage

// ==== result_fifo.sv ====
`timescale 1ns/100ps
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign push = wr_valid_in && (cnt_q < (PW+1)'(DEPTH));
  assign pop  = rd_ready_in && (cnt_q != '0);
  assign wr_ready_out = cnt_q < (PW+1)'(DEPTH);
  assign rd_valid_out = cnt_q != '0;
  assign rd_data_out  = mem_q[rp_q];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ==== pcm_tone_filter_bank.sv ====
`timescale 1ns/100ps
module pcm_tone_filter_bank
  import tone_filter_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        rx_pcm_bit_in,
  input  wire logic        rx_pcm_enable_in,
  input  wire logic [4:0]  rx_channel_in,
  input  wire logic [4:0]  test_channel_in,
  input  wire logic        test_start_in,
  input  wire logic        sel_req_in,
  input  wire logic [12:0] sel_req_data_in,
  output logic             sel_ack_out,
  output logic [7:0]       sel_rdata_out,
  input  wire logic        coef_we_in,
  input  wire logic [4:0]  coef_addr_in,
  input  wire logic [15:0] coef_wdata_in,
  output logic [15:0]      coef_rdata_out,
  input  wire logic        tx_req_in,
  input  wire logic [7:0]  tx_data_in,
  output logic             tx_pcm_bit_out,
  output logic             tx_pcm_enable_out,
  output logic             tx_busy_out,
  output logic [13:0]      dma_data_out,
  output logic             dma_valid_out,
  input  wire logic        dma_ready_in,
  output logic             group_busy_out
);
  typedef enum logic [1:0] {ACC_IDLE, ACC_RUN, ACC_DUMP} acc_state_type;

  // pin synchronisers
  logic [1:0] bit_sync_q;
  logic [1:0] en_sync_q;
  logic [4:0] ch_sync1_q;
  logic [4:0] ch_sync2_q;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      bit_sync_q <= '0;
      en_sync_q  <= '0;
      ch_sync1_q <= '0;
      ch_sync2_q <= '0;
    end else begin
      bit_sync_q <= {bit_sync_q[0], rx_pcm_bit_in};
      en_sync_q  <= {en_sync_q[0], rx_pcm_enable_in};
      ch_sync1_q <= rx_channel_in;
      ch_sync2_q <= ch_sync1_q;
    end
  end

  // serial input stage
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] held_q;
  logic       held_valid_q;
  logic       take_sample;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      shift_q      <= '0;
      bit_cnt_q    <= '0;
      held_q       <= '0;
      held_valid_q <= 1'b0;
    end else begin
      if (en_sync_q[1]) begin
        shift_q   <= {shift_q[6:0], bit_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
      if (en_sync_q[1] && bit_cnt_q == 3'h7 && ch_sync2_q == test_channel_in) begin
        held_q       <= {shift_q[6:0], bit_sync_q[1]};
        held_valid_q <= 1'b1;
      end else if (take_sample) begin
        held_valid_q <= 1'b0;
      end
    end
  end

  // select RAM, coefficient RAM
  logic [7:0]  sel_ram_q [16];
  logic [15:0] coef_ram_q [FILTER_COUNT];
  cpu_req_type req;
  assign req = cpu_req_type'(sel_req_data_in);
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 16; i++) begin
        sel_ram_q[i] <= SEL_RESET_VAL;
      end
    end else if (sel_req_in && req.write) begin
      sel_ram_q[req.addr] <= req.data;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (coef_we_in) begin
      coef_ram_q[coef_addr_in] <= coef_wdata_in;
    end
    // ram contents survive reset, only the read port clears
    if (srst_in) begin
      coef_rdata_out <= '0;
    end else begin
      coef_rdata_out <= coef_ram_q[coef_addr_in];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sel_ack_out   <= 1'b0;
      sel_rdata_out <= '0;
    end else begin
      sel_ack_out <= sel_req_in;
      if (sel_req_in && !req.write) begin
        sel_rdata_out <= sel_ram_q[req.addr];
      end
    end
  end

  // latched test setup
  logic [1:0] table_q;
  logic [3:0] active_q;
  logic [4:0] filt_q [ACTIVE_MAX];
  acc_state_type state_q;
  logic [6:0] samp_cnt_q;
  logic [3:0] dump_slot_q;
  logic [1:0] dump_byte_q;
  logic       fifo_ready;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      table_q  <= '0;
      active_q <= '0;
      for (int i = 0; i < ACTIVE_MAX; i++) begin
        filt_q[i] <= '0;
      end
    end else if (test_start_in && state_q == ACC_IDLE) begin
      table_q  <= sel_ram_q[SEL_TABLE_SLOT][1:0];
      active_q <= (sel_ram_q[SEL_COUNT_SLOT][3:0] > 4'(ACTIVE_MAX)) ?
                  4'(ACTIVE_MAX) : sel_ram_q[SEL_COUNT_SLOT][3:0];
      for (int i = 0; i < ACTIVE_MAX; i++) begin
        filt_q[i] <= sel_ram_q[i][4:0];
      end
    end
  end

  // linearisation, tables differ in sign and segment scaling
  function automatic logic [15:0] linearise(input logic [7:0] code, input logic [1:0] tbl);
    logic [7:0]  c;
    logic [15:0] mag;
    c   = tbl[0] ? (code ^ 8'h55) : ~code;
    mag = ({11'h000, c[3:0], 1'b1} << c[6:4]) << tbl[1];
    linearise = c[7] ? mag : 16'(-mag);
  endfunction

  // ten accumulators, filter = coefficient scaled sample
  logic signed [23:0] acc_q [ACTIVE_MAX];
  logic signed [15:0] lin;
  assign lin = signed'(linearise(held_q, table_q));
  assign take_sample = held_valid_q && state_q == ACC_RUN;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < ACTIVE_MAX; i++) begin
        acc_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ACTIVE_MAX; i++) begin
        if (take_sample && 4'(i) < active_q) begin
          // zero feedback on first sample after dump
          acc_q[i] <= ((samp_cnt_q == '0) ? 24'sh000000 : acc_q[i]) +
                      24'((32'(lin) * 32'(signed'(coef_ram_q[filt_q[i]]))) >>> 15);
        end
      end
    end
  end

  // group sequencer
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q     <= ACC_IDLE;
      samp_cnt_q  <= '0;
      dump_slot_q <= '0;
      dump_byte_q <= '0;
    end else begin
      case (state_q)
        ACC_IDLE: begin
          if (test_start_in) begin
            state_q    <= ACC_RUN;
            samp_cnt_q <= '0;
          end
        end
        ACC_RUN: begin
          if (take_sample) begin
            if (samp_cnt_q == 7'(GROUP_SAMPLES - 1)) begin
              state_q     <= (active_q == '0) ? ACC_IDLE : ACC_DUMP;
              dump_slot_q <= '0;
              dump_byte_q <= '0;
            end
            samp_cnt_q <= samp_cnt_q + 1'b1;
          end
        end
        ACC_DUMP: begin
          if (fifo_ready) begin
            if (dump_byte_q == 2'(RESULT_BYTES - 1)) begin
              dump_byte_q <= '0;
              if (dump_slot_q == active_q - 1'b1) begin
                state_q    <= ACC_IDLE;
                samp_cnt_q <= '0;
              end
              dump_slot_q <= dump_slot_q + 1'b1;
            end else begin
              dump_byte_q <= dump_byte_q + 1'b1;
            end
          end
        end
        default: state_q <= ACC_IDLE;
      endcase
    end
  end

  result_byte_type rb;
  logic [23:0]     dump_word;
  assign dump_word      = acc_q[dump_slot_q];
  assign rb.filter_slot = dump_slot_q;
  assign rb.byte_index  = dump_byte_q;
  assign rb.data        = dump_word[8'(23 - 8 * int'(dump_byte_q)) -: 8];

  logic [13:0] fifo_data;
  logic        fifo_valid;
  result_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_result_fifo (
    .ref_clk_in   (ref_clk_in),
    .srst_in      (srst_in),
    .wr_data_in   (rb),
    .wr_valid_in  (state_q == ACC_DUMP),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (!dma_valid_out || dma_ready_in)
  );

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dma_valid_out  <= 1'b0;
      dma_data_out   <= '0;
      group_busy_out <= 1'b0;
    end else begin
      group_busy_out <= state_q != ACC_IDLE;
      if (!dma_valid_out || dma_ready_in) begin
        dma_valid_out <= fifo_valid;
        dma_data_out  <= fifo_data;
      end
    end
  end

  logic [7:0] tx_shift_q;
  logic [3:0] tx_cnt_q;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      tx_shift_q        <= '0;
      tx_cnt_q          <= '0;
      tx_pcm_bit_out    <= 1'b0;
      tx_pcm_enable_out <= 1'b0;
      tx_busy_out       <= 1'b0;
    end else if (tx_cnt_q != '0) begin
      tx_pcm_bit_out    <= tx_shift_q[7];
      tx_pcm_enable_out <= 1'b1;
      tx_shift_q        <= {tx_shift_q[6:0], 1'b0};
      tx_cnt_q          <= tx_cnt_q - 1'b1;
      tx_busy_out       <= tx_cnt_q != 4'h1;
    end else begin
      tx_pcm_enable_out <= 1'b0;
      tx_pcm_bit_out    <= 1'b0;
      if (tx_req_in) begin
        tx_shift_q  <= tx_data_in;
        tx_cnt_q    <= 4'(PCM_BITS);
        tx_busy_out <= 1'b1;
      end
    end
  end
endmodule

// ==== pcm_tone_filter_bank_monitor.sv ====
`timescale 1ns/100ps
module pcm_tone_filter_bank_monitor (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        sel_req_in,
  input wire logic        sel_ack_out,
  input wire logic        test_start_in,
  input wire logic        group_busy_out,
  input wire logic        tx_req_in,
  input wire logic        tx_busy_out,
  input wire logic        tx_pcm_enable_out,
  input wire logic [13:0] dma_data_out,
  input wire logic        dma_valid_out,
  input wire logic        dma_ready_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  a_sel_ack_next: assert property (sel_req_in |=> sel_ack_out)
    else $error("select ack late");
  a_sel_ack_cause: assert property (sel_ack_out |-> $past(sel_req_in))
    else $error("select ack unasked");
  a_dma_data_hold: assert property (dma_valid_out && !dma_ready_in |=> dma_valid_out && $stable(dma_data_out))
    else $error("dma word dropped");
  a_dma_byte_index: assert property (dma_valid_out |-> dma_data_out[9:8] != 2'h3)
    else $error("dma byte index");
  a_dma_slot_range: assert property (dma_valid_out |-> dma_data_out[13:10] < 4'hA)
    else $error("dma slot range");
  a_tx_start_next: assert property (tx_req_in && !tx_busy_out |=> tx_busy_out && !tx_pcm_enable_out ##1 tx_pcm_enable_out)
    else $error("tx start late");
  a_tx_eight_bits: assert property ($rose(tx_pcm_enable_out) |-> tx_pcm_enable_out[*8] ##1 !tx_pcm_enable_out)
    else $error("tx length");
  a_group_start: assert property (test_start_in && !group_busy_out |-> ##2 group_busy_out)
    else $error("group not started");
  c_dma_stall: cover property (dma_valid_out && !dma_ready_in);
  c_sel_ack: cover property (sel_req_in ##1 sel_ack_out);
  c_tx_frame: cover property ($rose(tx_pcm_enable_out));
endmodule

bind pcm_tone_filter_bank pcm_tone_filter_bank_monitor u_pcm_tone_filter_bank_monitor (.ref_clk_in, .srst_in,
  .sel_req_in, .sel_ack_out, .test_start_in, .group_busy_out, .tx_req_in, .tx_busy_out, .tx_pcm_enable_out,
  .dma_data_out, .dma_valid_out, .dma_ready_in);

// ==== dma_sink_model.sv ====
`timescale 1ns/100ps
module dma_sink_model (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        slow_in,
  input wire logic [13:0] dma_data_in,
  input wire logic        dma_valid_in,
  output logic            dma_ready_out
);
  logic [13:0] got[$];
  logic        phase_q;
  // slow mode stalls every other cycle
  assign dma_ready_out = !srst_in && (!slow_in || phase_q);
  always @(posedge ref_clk_in) begin
    phase_q <= srst_in ? 1'b0 : ~phase_q;
    if (!srst_in && dma_valid_in && dma_ready_out) begin
      got.push_back(dma_data_in);
    end
  end
endmodule

// ==== pcm_tone_filter_bank_tb.sv ====
`timescale 1ns/100ps
module pcm_tone_filter_bank_tb;
  import tone_filter_pkg::*;
  logic ref_clk_in = 0, srst_in = 1, rx_pcm_bit_in = 0, rx_pcm_enable_in = 0, test_start_in = 0;
  logic sel_req_in = 0, coef_we_in = 0, tx_req_in = 0, slow = 0, dma_ready_in;
  logic [4:0] rx_channel_in = 0, test_channel_in = 0, coef_addr_in = 0;
  logic [12:0] sel_req_data_in = 0;
  logic [15:0] coef_wdata_in = 0, coef_rdata_out;
  logic [7:0] tx_data_in = 0, sel_rdata_out;
  logic sel_ack_out, tx_pcm_bit_out, tx_pcm_enable_out, tx_busy_out, dma_valid_out, group_busy_out;
  logic [13:0] dma_data_out;
  int mismatches = 0;
  int num_checks = 0;
  pcm_tone_filter_bank u_pcm_tone_filter_bank (
    .ref_clk_in        (ref_clk_in),
    .srst_in           (srst_in),
    .rx_pcm_bit_in     (rx_pcm_bit_in),
    .rx_pcm_enable_in  (rx_pcm_enable_in),
    .rx_channel_in     (rx_channel_in),
    .test_channel_in   (test_channel_in),
    .test_start_in     (test_start_in),
    .sel_req_in        (sel_req_in),
    .sel_req_data_in   (sel_req_data_in),
    .sel_ack_out       (sel_ack_out),
    .sel_rdata_out     (sel_rdata_out),
    .coef_we_in        (coef_we_in),
    .coef_addr_in      (coef_addr_in),
    .coef_wdata_in     (coef_wdata_in),
    .coef_rdata_out    (coef_rdata_out),
    .tx_req_in         (tx_req_in),
    .tx_data_in        (tx_data_in),
    .tx_pcm_bit_out    (tx_pcm_bit_out),
    .tx_pcm_enable_out (tx_pcm_enable_out),
    .tx_busy_out       (tx_busy_out),
    .dma_data_out      (dma_data_out),
    .dma_valid_out     (dma_valid_out),
    .dma_ready_in      (dma_ready_in),
    .group_busy_out    (group_busy_out)
  );
  dma_sink_model u_dma_sink_model (.ref_clk_in, .srst_in, .slow_in(slow), .dma_data_in(dma_data_out),
    .dma_valid_in(dma_valid_out), .dma_ready_out(dma_ready_in));
  always #5 ref_clk_in = ~ref_clk_in;
  // shelf sends a toggling bit stream
  always @(posedge ref_clk_in) rx_pcm_bit_in <= #1 ~rx_pcm_bit_in;
  // two interleaved channels, number moves after each eighth enabled bit
  logic [2:0] rx_bit_idx = 0;
  always @(posedge ref_clk_in) begin
    if (!srst_in && rx_pcm_enable_in) begin
      rx_bit_idx <= rx_bit_idx + 1'b1;
      if (rx_bit_idx == 3'h7) rx_channel_in <= #1 rx_channel_in ^ 5'h01;
    end
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // requests may run back to back, caller releases the strobe
  task automatic sel_access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    cpu_req_type r;
    r = '{data: d, addr: a, write: wr};
    sel_req_data_in = r;
    sel_req_in = 1;
    step();
    check(sel_ack_out, 1'b1);
    q = sel_rdata_out;
  endtask
  task automatic coef_write(input logic [4:0] a, input logic [15:0] d);
    coef_addr_in = a;
    coef_wdata_in = d;
    coef_we_in = 1;
    step();
    coef_we_in = 0;
    step();
    check(coef_rdata_out, d);
  endtask
  task automatic test_sel_ram;
    logic [7:0] q;
    for (int a = 0; a < 12; a++) begin
      sel_access(1'b0, 4'(a), 8'h00, q);
      check(q, SEL_RESET_VAL);
    end
    for (int a = 0; a < 10; a++) sel_access(1'b1, 4'(a), 8'(a + 3), q);
    for (int a = 0; a < 10; a++) begin
      sel_access(1'b0, 4'(a), 8'h00, q);
      check(q, 8'(a + 3));
    end
    sel_req_in = 0;
  endtask
  task automatic test_tx(input logic [7:0] d);
    tx_data_in = d;
    tx_req_in = 1;
    step();
    tx_req_in = 0;
    // first bit leaves one cycle after the request is taken
    step();
    for (int i = 7; i >= 0; i--) begin
      check({tx_pcm_enable_out, tx_pcm_bit_out}, {1'b1, d[i]});
      check(tx_busy_out, i != 0);
      step();
    end
    check(tx_pcm_enable_out, 1'b0);
  endtask
  // zero coefficient gives zero sums only if each group starts afresh
  task automatic test_group(input logic [1:0] tbl, input logic [15:0] c1, input logic stall, input logic hold);
    logic [7:0] q;
    logic [13:0] e;
    int n;
    coef_write(5'h01, c1);
    coef_write(5'h02, 16'h0000);
    sel_access(1'b1, 4'h0, 8'h01, q);
    sel_access(1'b1, 4'h1, 8'h02, q);
    sel_access(1'b1, SEL_TABLE_SLOT, {6'h00, tbl}, q);
    sel_access(1'b1, SEL_COUNT_SLOT, 8'h02, q);
    sel_req_in = 0;
    slow = stall;
    rx_pcm_enable_in = !hold;
    test_channel_in = {4'h0, tbl[0]};
    u_dma_sink_model.got.delete();
    test_start_in = 1;
    step();
    test_start_in = 0;
    // count rewritten mid-group must not change this group
    sel_access(1'b1, SEL_COUNT_SLOT, 8'h01, q);
    sel_req_in = 0;
    if (hold) begin
      step(700);
      check(16'(u_dma_sink_model.got.size()), 16'h0000);
      check(group_busy_out, 1'b1);
      rx_pcm_enable_in = 1;
    end
    for (n = 0; n < 4000 && u_dma_sink_model.got.size() < 6; n++) step();
    // one kept byte every 16 bits, so 64 samples take about a thousand cycles
    check(16'(n > 900), 16'h0001);
    for (int k = 0; k < 100 && group_busy_out !== 1'b0; k++) step();
    check(group_busy_out, 1'b0);
    check(16'(u_dma_sink_model.got.size()), 16'h0006);
    for (int i = 0; i < 6; i++) begin
      e = u_dma_sink_model.got[i];
      check(e[13:8], {4'(i / 3), 2'(i % 3)});
      if (i > 2 || c1 == 0) check(e[7:0], 8'h00);
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    complete_run();
  end
  initial begin
    step(20);
    srst_in = 0;
    rx_pcm_enable_in = 1;
    test_sel_ram();
    test_tx(8'hA5);
    test_tx(8'h3C);
    test_group(2'h0, 16'h4000, 1'b0, 1'b0);
    test_group(2'h1, 16'h0000, 1'b1, 1'b1);
    test_group(2'h2, 16'h2000, 1'b1, 1'b0);
    test_group(2'h3, 16'h0000, 1'b0, 1'b0);
    complete_run();
  end
endmodule
